// ### design/cgsc_pkg.sv
// Package for the clock gate and source select controller.
// Assumes one 100 MHz system clock and byte addresses on the register port.
package cgsc_pkg;

  localparam int unsigned CLK_RATE_MHZ = 100;
  localparam int unsigned SWITCH_SETTLE_NS = 20;
  localparam int unsigned SWITCH_SETTLE_CYC =
    (SWITCH_SETTLE_NS * CLK_RATE_MHZ + 999) / 1000;

  localparam logic [7:0] OFS_SYS_GATES = 8'h04;
  localparam logic [7:0] OFS_PERIPH_GATES = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CORE_TICK = 8'h10;
  localparam logic [7:0] OFS_PERIPH_SRC = 8'h14;

  localparam int unsigned BIT_EXT_BUS = 3;
  localparam int unsigned BIT_FLASH_PROG = 2;

  localparam int unsigned BIT_COMPARATOR = 30;
  localparam int unsigned BIT_CONVERTER = 28;
  localparam int unsigned BIT_PWM_PAIR0 = 20;
  localparam int unsigned BIT_SERIAL0 = 16;
  localparam int unsigned BIT_SPI0 = 12;
  localparam int unsigned BIT_I2C = 8;
  localparam int unsigned BIT_FREQ_DIV = 6;
  localparam int unsigned BIT_TIMER0 = 2;
  localparam int unsigned BIT_WATCHDOG = 0;

  localparam int unsigned BIT_SWITCH_FAIL = 7;
  localparam int unsigned BIT_FAST_RC = 4;
  localparam int unsigned BIT_SLOW_RC = 3;
  localparam int unsigned BIT_PLL = 2;
  localparam int unsigned BIT_CRYSTAL = 0;

  localparam int unsigned POS_TICK_SRC = 3;
  localparam int unsigned POS_CORE_SRC = 0;

  localparam int unsigned POS_PWM_PAIR1_SRC = 30;
  localparam int unsigned POS_PWM_PAIR0_SRC = 28;
  localparam int unsigned POS_SERIAL_SRC = 24;
  localparam int unsigned POS_TIMER3_SRC = 20;
  localparam int unsigned POS_TIMER2_SRC = 16;
  localparam int unsigned POS_TIMER1_SRC = 12;
  localparam int unsigned POS_TIMER0_SRC = 8;
  localparam int unsigned POS_CONVERTER_SRC = 2;
  localparam int unsigned POS_WATCHDOG_SRC = 0;

  // Core clock source codes
  localparam logic [2:0] SRC_CRYSTAL = 3'h0;
  localparam logic [2:0] SRC_PLL = 3'h2;
  localparam logic [2:0] SRC_SLOW_RC = 3'h3;
  localparam logic [2:0] SRC_FAST_RC = 3'h7;
  // Tick clock source codes
  localparam logic [2:0] TICK_CRYSTAL = 3'h0;
  localparam logic [2:0] TICK_CRYSTAL_DIV2 = 3'h2;
  localparam logic [2:0] TICK_CORE_DIV2 = 3'h3;
  localparam logic [2:0] TICK_FAST_RC_DIV2 = 3'h7;

  localparam logic [1:0] RST_SYS_GATES = 2'h3;
  localparam logic [2:0] RST_TICK_SRC = 3'h7;
  localparam logic RST_WATCHDOG_GATE = 1'h1;
  localparam logic [31:0] RST_PERIPH_SRC = 32'hffff_ffff;

  typedef struct packed {
    logic ext_bus_ctrl_clk_gate;
    logic flash_prog_clk_gate;
  } cgsc_sys_gates_s;

  typedef struct packed {
    logic comparator_clk_gate;
    logic converter_clk_gate;
    logic [3:0] pwm_pair_clk_gate;
    logic [1:0] serial_port_clk_gate;
    logic [1:0] spi_port_clk_gate;
    logic i2c_clk_gate;
    logic freq_divider_clk_gate;
    logic [3:0] timer_clk_gate;
    logic watchdog_clk_gate;
  } cgsc_periph_gates_s;

  typedef struct packed {
    logic [1:0] pwm_pair1_source;
    logic [1:0] pwm_pair0_source;
    logic [1:0] serial_port_source;
    logic [2:0] timer3_source;
    logic [2:0] timer2_source;
    logic [2:0] timer1_source;
    logic [2:0] timer0_source;
    logic [1:0] converter_source;
    logic [1:0] watchdog_source;
  } cgsc_periph_src_s;

  typedef struct packed {
    logic fast_rc_stable;
    logic slow_rc_stable;
    logic pll_locked_stable;
    logic crystal_stable;
  } cgsc_stable_s;

  // One-hot select: bit0 crystal, bit1 PLL, bit2 slow RC, bit3 fast RC
  function automatic logic [3:0] cgsc_src_onehot(input logic [2:0] code);
    case (code)
      SRC_CRYSTAL: cgsc_src_onehot = 4'h1;
      SRC_PLL: cgsc_src_onehot = 4'h2;
      SRC_SLOW_RC: cgsc_src_onehot = 4'h4;
      SRC_FAST_RC: cgsc_src_onehot = 4'h8;
      default: cgsc_src_onehot = 4'h0;
    endcase
  endfunction

endpackage

// ### design/cgsc_sync2.sv
// Two-flop synchroniser for oscillator and PLL stability levels.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ns
module cgsc_sync2 #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // cgsc_sync2

// ### design/cgsc_switch_seq.sv
// Break-before-make sequencer for the core clock source select.
// Assumes start is only raised for a valid, stable target.
`timescale 1ns/1ns
module cgsc_switch_seq
  import cgsc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [2:0] boot_code_in,
  input wire logic start_in,
  input wire logic [2:0] target_in,
  output logic [2:0] active_out,
  output logic [3:0] select_out,
  output logic busy_out
);

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_DROP = 2'b10
  } cgsc_seq_e;

  cgsc_seq_e state_q;
  logic [2:0] target_q;
  logic [7:0] settle_q;

  // Old select is dropped and all lines idle before the new one rises
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= ST_RUN;
      target_q <= boot_code_in;
      settle_q <= 8'h0;
      active_out <= boot_code_in;
      select_out <= cgsc_src_onehot(boot_code_in);
      busy_out <= 1'b0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (start_in) begin
            state_q <= ST_DROP;
            target_q <= target_in;
            settle_q <= 8'(SWITCH_SETTLE_CYC);
            select_out <= 4'h0;
            busy_out <= 1'b1;
          end
        end
        ST_DROP: begin
          if (settle_q <= 8'h1) begin
            state_q <= ST_RUN;
            active_out <= target_q;
            select_out <= cgsc_src_onehot(target_q);
            busy_out <= 1'b0;
          end else begin
            settle_q <= settle_q - 8'h1;
          end
        end
        default: begin
          state_q <= ST_RUN;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // cgsc_switch_seq

// ### design/cgsc_top.sv
// Clock gate and source select controller: gate bits, stability status,
// core and tick source selects and peripheral source selects.
// Assumes a single-cycle register port on the system clock, a write-unlock
// level from the protection logic and asynchronous stability levels.
`timescale 1ns/1ns

// Operation
// - Bit 3 gates external bus controller clock
// - Bit 2 gates flash programming controller clock
// - Bit 30 gates comparator clock
// - Bit 28 gates converter clock
// - Bits 23:20 gate PWM pairs 3..0
// - Bits 17,16 gate serial ports 1,0
// - Bits 13,12 SPI ports; bit 8 I2C
// - Bit 6 gates frequency divider clock
// - Bits 5:2 gate timers 3..0
// - Bit 0 watchdog gate, writable only unlocked
// - Unstable switch target sets switch-failed flag
// - Writing one clears switch-failed flag
// - Status bit 4 shows fast RC stable
// - Status bit 3 shows slow RC stable
// - Status bit 2 shows PLL stable
// - Status bit 0 shows crystal stable
// - Tick source field 5:3, protected, four codes
// - Core source field 2:0, protected, four codes
// - Core source reloads from boot config
// - Peripheral source register resets all ones
module cgsc_top
  import cgsc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic reg_unlock_in,
  input wire logic boot_oscillator_config_in,
  input wire cgsc_stable_s stable_in,
  output cgsc_sys_gates_s sys_gates_out,
  output cgsc_periph_gates_s periph_gates_out,
  output cgsc_periph_src_s periph_source_out,
  output logic [2:0] tick_clock_source_out,
  output logic [2:0] core_clock_source_out,
  output logic [3:0] core_clock_select_out,
  output logic core_switch_busy_out
);

  cgsc_stable_s stable_sync;
  logic clock_switch_failed_q;
  logic [2:0] boot_code;
  logic [2:0] req_core;
  logic [2:0] req_tick;
  logic req_core_valid;
  logic req_tick_valid;
  logic target_stable;
  logic wr_sys_gates;
  logic wr_periph_gates;
  logic wr_status;
  logic wr_core_tick;
  logic wr_periph_src;
  logic switch_start;
  logic switch_fail;
  logic core_wr_ok;
  logic tick_wr_ok;
  logic [31:0] rd_data_d;

  cgsc_sync2 #(
    .WIDTH(4)
  ) u_stable_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(stable_in),
    .sync_out(stable_sync)
  );

  // Boot config bit selects the reset-time core source
  assign boot_code = boot_oscillator_config_in ? SRC_FAST_RC
                                               : SRC_CRYSTAL;

  // One write strobe per register; unmapped addresses fall through
  always_comb begin
    wr_sys_gates = 1'b0;
    wr_periph_gates = 1'b0;
    wr_status = 1'b0;
    wr_core_tick = 1'b0;
    wr_periph_src = 1'b0;
    if (wr_in) begin
      case (addr_in)
        OFS_SYS_GATES: wr_sys_gates = 1'b1;
        OFS_PERIPH_GATES: wr_periph_gates = 1'b1;
        OFS_STATUS: wr_status = 1'b1;
        OFS_CORE_TICK: wr_core_tick = 1'b1;
        OFS_PERIPH_SRC: wr_periph_src = 1'b1;
        default: wr_sys_gates = 1'b0;
      endcase
    end
  end

  assign req_core = wr_data_in[POS_CORE_SRC +: 3];
  assign req_tick = wr_data_in[POS_TICK_SRC +: 3];

  always_comb begin
    case (req_core)
      SRC_CRYSTAL: target_stable = stable_sync.crystal_stable;
      SRC_PLL: target_stable = stable_sync.pll_locked_stable;
      SRC_SLOW_RC: target_stable = stable_sync.slow_rc_stable;
      SRC_FAST_RC: target_stable = stable_sync.fast_rc_stable;
      default: target_stable = 1'b0;
    endcase
  end

  always_comb begin
    case (req_core)
      SRC_CRYSTAL, SRC_PLL, SRC_SLOW_RC, SRC_FAST_RC:
        req_core_valid = 1'b1;
      default:
        req_core_valid = 1'b0;
    endcase
  end

  always_comb begin
    case (req_tick)
      TICK_CRYSTAL, TICK_CRYSTAL_DIV2, TICK_CORE_DIV2, TICK_FAST_RC_DIV2:
        req_tick_valid = 1'b1;
      default:
        req_tick_valid = 1'b0;
    endcase
  end

  // Core field write: protected, idle only, known source code
  assign core_wr_ok = wr_core_tick && reg_unlock_in && req_core_valid &&
                      !core_switch_busy_out;

  // A new core source is taken only when stable and differing
  assign switch_start = core_wr_ok &&
                        target_stable &&
                        (req_core != core_clock_source_out);
  assign switch_fail = core_wr_ok &&
                       !target_stable;

  // Tick field shares the write protection; reserved codes are dropped
  assign tick_wr_ok = wr_core_tick && reg_unlock_in && req_tick_valid;

  cgsc_switch_seq u_switch_seq (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .boot_code_in(boot_code),
    .start_in(switch_start),
    .target_in(req_core),
    .active_out(core_clock_source_out),
    .select_out(core_clock_select_out),
    .busy_out(core_switch_busy_out)
  );

  // System-bus master clock gates
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sys_gates_out <= cgsc_sys_gates_s'(RST_SYS_GATES);
    end else if (wr_sys_gates) begin
      sys_gates_out.ext_bus_ctrl_clk_gate <=
        wr_data_in[BIT_EXT_BUS];
      sys_gates_out.flash_prog_clk_gate <=
        wr_data_in[BIT_FLASH_PROG];
    end
  end

  // Peripheral clock gates
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      periph_gates_out <= '0;
      periph_gates_out.watchdog_clk_gate <= RST_WATCHDOG_GATE;
    end else if (wr_periph_gates) begin
      periph_gates_out.comparator_clk_gate <=
        wr_data_in[BIT_COMPARATOR];
      periph_gates_out.converter_clk_gate <=
        wr_data_in[BIT_CONVERTER];
      periph_gates_out.pwm_pair_clk_gate <=
        wr_data_in[BIT_PWM_PAIR0 +: 4];
      periph_gates_out.serial_port_clk_gate <=
        wr_data_in[BIT_SERIAL0 +: 2];
      periph_gates_out.spi_port_clk_gate <=
        wr_data_in[BIT_SPI0 +: 2];
      periph_gates_out.i2c_clk_gate <=
        wr_data_in[BIT_I2C];
      periph_gates_out.freq_divider_clk_gate <=
        wr_data_in[BIT_FREQ_DIV];
      periph_gates_out.timer_clk_gate <=
        wr_data_in[BIT_TIMER0 +: 4];
      // Watchdog gate needs the write protection released
      if (reg_unlock_in) begin
        periph_gates_out.watchdog_clk_gate <=
          wr_data_in[BIT_WATCHDOG];
      end
    end
  end

  // Sticky switch failure; a new failure wins over a clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      clock_switch_failed_q <= 1'b0;
    end else if (switch_fail) begin
      clock_switch_failed_q <= 1'b1;
    end else if (wr_status && wr_data_in[BIT_SWITCH_FAIL]) begin
      clock_switch_failed_q <= 1'b0;
    end
  end

  // Tick source is a plain protected select; reserved codes are dropped
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tick_clock_source_out <= RST_TICK_SRC;
    end else if (tick_wr_ok) begin
      tick_clock_source_out <= req_tick;
    end
  end

  // Peripheral source selects; watchdog select is write-protected
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      periph_source_out <= '1;
    end else if (wr_periph_src) begin
      periph_source_out.pwm_pair1_source <=
        wr_data_in[POS_PWM_PAIR1_SRC +: 2];
      periph_source_out.pwm_pair0_source <=
        wr_data_in[POS_PWM_PAIR0_SRC +: 2];
      periph_source_out.serial_port_source <=
        wr_data_in[POS_SERIAL_SRC +: 2];
      periph_source_out.timer3_source <=
        wr_data_in[POS_TIMER3_SRC +: 3];
      periph_source_out.timer2_source <=
        wr_data_in[POS_TIMER2_SRC +: 3];
      periph_source_out.timer1_source <=
        wr_data_in[POS_TIMER1_SRC +: 3];
      periph_source_out.timer0_source <=
        wr_data_in[POS_TIMER0_SRC +: 3];
      periph_source_out.converter_source <=
        wr_data_in[POS_CONVERTER_SRC +: 2];
      // Watchdog source needs the write protection released
      if (reg_unlock_in) begin
        periph_source_out.watchdog_source <=
          wr_data_in[POS_WATCHDOG_SRC +: 2];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_data_d = 32'h0;
    case (addr_in)
      OFS_SYS_GATES: begin
        rd_data_d[BIT_EXT_BUS] =
          sys_gates_out.ext_bus_ctrl_clk_gate;
        rd_data_d[BIT_FLASH_PROG] =
          sys_gates_out.flash_prog_clk_gate;
      end

      OFS_PERIPH_GATES: begin
        rd_data_d[BIT_COMPARATOR] =
          periph_gates_out.comparator_clk_gate;
        rd_data_d[BIT_CONVERTER] =
          periph_gates_out.converter_clk_gate;
        rd_data_d[BIT_PWM_PAIR0 +: 4] =
          periph_gates_out.pwm_pair_clk_gate;
        rd_data_d[BIT_SERIAL0 +: 2] =
          periph_gates_out.serial_port_clk_gate;
        rd_data_d[BIT_SPI0 +: 2] =
          periph_gates_out.spi_port_clk_gate;
        rd_data_d[BIT_I2C] =
          periph_gates_out.i2c_clk_gate;
        rd_data_d[BIT_FREQ_DIV] =
          periph_gates_out.freq_divider_clk_gate;
        rd_data_d[BIT_TIMER0 +: 4] =
          periph_gates_out.timer_clk_gate;
        rd_data_d[BIT_WATCHDOG] =
          periph_gates_out.watchdog_clk_gate;
      end

      // Stability bits come from the synchroniser, not the raw levels
      OFS_STATUS: begin
        rd_data_d[BIT_SWITCH_FAIL] =
          clock_switch_failed_q;
        rd_data_d[BIT_FAST_RC] =
          stable_sync.fast_rc_stable;
        rd_data_d[BIT_SLOW_RC] =
          stable_sync.slow_rc_stable;
        rd_data_d[BIT_PLL] =
          stable_sync.pll_locked_stable;
        rd_data_d[BIT_CRYSTAL] =
          stable_sync.crystal_stable;
      end

      // Core field reads the active source, not a pending request
      OFS_CORE_TICK: begin
        rd_data_d[POS_TICK_SRC +: 3] =
          tick_clock_source_out;
        rd_data_d[POS_CORE_SRC +: 3] =
          core_clock_source_out;
      end

      OFS_PERIPH_SRC: begin
        // Reserved bits read as one, matching the all-ones reset value
        rd_data_d = RST_PERIPH_SRC;
        rd_data_d[POS_PWM_PAIR1_SRC +: 2] =
          periph_source_out.pwm_pair1_source;
        rd_data_d[POS_PWM_PAIR0_SRC +: 2] =
          periph_source_out.pwm_pair0_source;
        rd_data_d[POS_SERIAL_SRC +: 2] =
          periph_source_out.serial_port_source;
        rd_data_d[POS_TIMER3_SRC +: 3] =
          periph_source_out.timer3_source;
        rd_data_d[POS_TIMER2_SRC +: 3] =
          periph_source_out.timer2_source;
        rd_data_d[POS_TIMER1_SRC +: 3] =
          periph_source_out.timer1_source;
        rd_data_d[POS_TIMER0_SRC +: 3] =
          periph_source_out.timer0_source;
        rd_data_d[POS_CONVERTER_SRC +: 2] =
          periph_source_out.converter_source;
        rd_data_d[POS_WATCHDOG_SRC +: 2] =
          periph_source_out.watchdog_source;
      end

      default: begin
        rd_data_d = 32'h0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0;
    end else if (rd_in) begin
      rd_data_out <= rd_data_d;
    end else begin
      rd_data_out <= 32'h0;
    end
  end

endmodule // cgsc_top

// ### sim/cgsc_top_monitor.sv
// Port assertions for the clock gate and source select controller.
// Assumes it is bound to cgsc_top: one clock, synchronous reset.
`timescale 1ns/1ns
module cgsc_top_monitor
  import cgsc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic reg_unlock_in,
  input wire logic boot_oscillator_config_in,
  input wire cgsc_stable_s stable_in,
  input wire cgsc_sys_gates_s sys_gates_out,
  input wire cgsc_periph_gates_s periph_gates_out,
  input wire cgsc_periph_src_s periph_source_out,
  input wire logic [2:0] tick_clock_source_out,
  input wire logic [2:0] core_clock_source_out,
  input wire logic [3:0] core_clock_select_out,
  input wire logic core_switch_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [31:0] d;
  logic [15:0] gate_map;
  logic [21:0] src_map;
  logic wr_gate, wr_sel, wr_src, tick_ok;
  assign d = wr_data_in;
  assign gate_map = {d[30], d[28], d[23:20], d[17:16], d[13:12], d[8], d[6],
    d[5:2]};
  assign src_map = {d[31:28], d[25:24], d[22:20], d[18:16], d[14:12],
    d[10:8], d[3:0]};
  assign wr_gate = wr_in && addr_in == OFS_PERIPH_GATES;
  assign wr_sel = wr_in && addr_in == OFS_CORE_TICK;
  assign wr_src = wr_in && addr_in == OFS_PERIPH_SRC;
  assign tick_ok = d[5:3] inside {3'h0, 3'h2, 3'h3, 3'h7};

  AST_SYS_GATES: assert property (
    wr_in && addr_in == OFS_SYS_GATES |=> sys_gates_out == $past(d[3:2]))
    else $error("system bus gates not loaded");
  AST_PERIPH_GATES: assert property (
    wr_gate |=> periph_gates_out[16:1] == $past(gate_map))
    else $error("peripheral gates not loaded");
  AST_WDOG_LOCK: assert property (
    wr_gate && !reg_unlock_in |=> $stable(periph_gates_out.watchdog_clk_gate))
    else $error("watchdog gate changed while locked");
  AST_WDOG_OPEN: assert property (
    wr_gate && reg_unlock_in |=>
      periph_gates_out.watchdog_clk_gate == $past(d[0]))
    else $error("watchdog gate not loaded while unlocked");
  AST_TICK_SET: assert property (
    wr_sel && reg_unlock_in && tick_ok |=>
      tick_clock_source_out == $past(d[5:3]))
    else $error("tick source not loaded");
  AST_TICK_KEEP: assert property (
    wr_sel && !(reg_unlock_in && tick_ok) |=> $stable(tick_clock_source_out))
    else $error("tick source changed on refused write");
  AST_SRC_SET: assert property (
    wr_src && reg_unlock_in |=> periph_source_out == $past(src_map))
    else $error("peripheral sources not loaded");
  AST_SRC_LOCK: assert property (
    wr_src && !reg_unlock_in |=> $stable(periph_source_out.watchdog_source))
    else $error("watchdog source changed while locked");
  AST_BUSY_LEN: assert property (
    $rose(core_switch_busy_out) |=> core_switch_busy_out ##1
      !core_switch_busy_out)
    else $error("switch settle length wrong");
  AST_SEL_BREAK: assert property (
    core_switch_busy_out |-> core_clock_select_out == 4'h0)
    else $error("clock selected during switch");
  AST_SEL_ONE: assert property (
    !core_switch_busy_out |-> $onehot(core_clock_select_out))
    else $error("core select not one-hot");
  AST_CORE_HOLD: assert property (
    $changed(core_clock_source_out) |-> $fell(core_switch_busy_out))
    else $error("core source changed outside a switch");
  AST_BOOT: assert property (
    $fell(rst_in) |-> core_clock_source_out ==
      (boot_oscillator_config_in ? SRC_FAST_RC : SRC_CRYSTAL) &&
      periph_source_out == 22'h3f_ffff)
    else $error("reset values wrong");
endmodule // cgsc_top_monitor

bind cgsc_top cgsc_top_monitor i_mon (
  .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .reg_unlock_in(reg_unlock_in),
  .boot_oscillator_config_in(boot_oscillator_config_in),
  .stable_in(stable_in), .sys_gates_out(sys_gates_out),
  .periph_gates_out(periph_gates_out),
  .periph_source_out(periph_source_out),
  .tick_clock_source_out(tick_clock_source_out),
  .core_clock_source_out(core_clock_source_out),
  .core_clock_select_out(core_clock_select_out),
  .core_switch_busy_out(core_switch_busy_out));

// ### sim/cgsc_top_tb.sv
// Self-checking bench for the clock gate and source select controller.
// Assumes the bound monitor; drives every input from this module.
`timescale 1ns/1ns
module cgsc_top_tb
  import cgsc_pkg::*;
;
  logic clock_in, rst_in, wr_in, rd_in, reg_unlock_in;
  logic boot_oscillator_config_in, core_switch_busy_out;
  logic rd_seen = 1'b0;
  logic [7:0] addr_in;
  logic [31:0] wr_data_in, rd_data_out, val, exp_g;
  logic [3:0] core_clock_select_out, sv;
  logic [2:0] tick_clock_source_out, core_clock_source_out, cur_core, cur_tick;
  cgsc_stable_s stable_in;
  cgsc_sys_gates_s sys_gates_out;
  cgsc_periph_gates_s periph_gates_out;
  cgsc_periph_src_s periph_source_out;
  logic [31:0] exp_q[$];
  logic [2:0] codes [4] = '{SRC_CRYSTAL, SRC_PLL, SRC_SLOW_RC, SRC_FAST_RC};
  logic [3:0] sels [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  int err_total = 0;
  int checks = 0;

  cgsc_top i_dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .reg_unlock_in(reg_unlock_in),
    .boot_oscillator_config_in(boot_oscillator_config_in),
    .stable_in(stable_in), .sys_gates_out(sys_gates_out),
    .periph_gates_out(periph_gates_out),
    .periph_source_out(periph_source_out),
    .tick_clock_source_out(tick_clock_source_out),
    .core_clock_source_out(core_clock_source_out),
    .core_clock_select_out(core_clock_select_out),
    .core_switch_busy_out(core_switch_busy_out));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr_in <= a;
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clock_in);
  endtask

  task automatic idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clock_in);
  endtask

  task automatic do_reset(input logic boot);
    boot_oscillator_config_in <= boot;
    rst_in <= 1'b1;
    idle(5);
    rst_in <= 1'b0;
    cur_core = boot ? SRC_FAST_RC : SRC_CRYSTAL;
    cur_tick = 3'h7;
    idle(1);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(rd_data_out, exp_q.pop_front());
    end
    rd_seen <= rd_in && !rst_in;
  end

  initial begin
    #300000;
    err_total++;
    summarize();
  end

  initial begin
    val = $urandom(11492);
    addr_in <= 8'h00;
    wr_data_in <= 32'h0;
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    reg_unlock_in <= 1'b1;
    stable_in <= 4'hf;
    do_reset(1'b1);
    rd(OFS_SYS_GATES, 32'h0000_000c);
    rd(OFS_PERIPH_GATES, 32'h0000_0001);
    rd(OFS_CORE_TICK, 32'h0000_003f);
    rd(OFS_PERIPH_SRC, 32'hffff_ffff);
    rd(8'h1c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      val = $urandom() & 32'h50f3_317d;
      wr(OFS_PERIPH_GATES, val);
      wr(OFS_SYS_GATES, val);
      idle(1);
      exp_g = {15'h0, val[30], val[28], val[23:20], val[17:16], val[13:12],
        val[8], val[6], val[5:2], val[0]};
      check(32'(periph_gates_out), exp_g);
      check(32'(sys_gates_out), {30'h0, val[3:2]});
      rd(OFS_PERIPH_GATES, val);
      rd(OFS_SYS_GATES, val & 32'h0000_000c);
      exp_g = $urandom();
      wr(OFS_PERIPH_SRC, exp_g);
      rd(OFS_PERIPH_SRC, exp_g | 32'h0c88_88f0);
    end
    // Protected fields refuse writes while locked
    reg_unlock_in <= 1'b0;
    wr(OFS_PERIPH_GATES, ~val & 32'h50f3_317d);
    wr(OFS_PERIPH_SRC, 32'h0);
    wr(OFS_CORE_TICK, 32'h0);
    rd(OFS_PERIPH_GATES, (~val & 32'h50f3_317c) | (val & 32'h1));
    rd(OFS_PERIPH_SRC, 32'h0c88_88f0 | (exp_g & 32'h3));
    rd(OFS_CORE_TICK, {26'h0, cur_tick, cur_core});
    idle(1);
    reg_unlock_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sv = 4'h1 << i;
      stable_in <= sv;
      idle(3);
      rd(OFS_STATUS, {27'h0, sv[3:1], 1'b0, sv[0]});
    end
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CORE_TICK, {26'h0, 3'(c), cur_core});
      if (3'(c) inside {3'h0, 3'h2, 3'h3, 3'h7}) cur_tick = 3'(c);
      rd(OFS_CORE_TICK, {26'h0, cur_tick, cur_core});
    end
    stable_in <= 4'hf;
    idle(3);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CORE_TICK, {26'h0, cur_tick, codes[k]});
      idle(1);
      check(32'(core_switch_busy_out), 32'h1);
      check(32'(core_clock_select_out), 32'h0);
      idle(2);
      check(32'(core_switch_busy_out), 32'h0);
      check(32'(core_clock_source_out), 32'(codes[k]));
      check(32'(core_clock_select_out), 32'(sels[k]));
      cur_core = codes[k];
      rd(OFS_CORE_TICK, {26'h0, cur_tick, cur_core});
    end
    // Switch to an unlocked but unstable PLL must fail and hold
    stable_in <= 4'hd;
    idle(3);
    wr(OFS_CORE_TICK, {26'h0, cur_tick, SRC_PLL});
    idle(3);
    check(32'(core_clock_source_out), 32'(cur_core));
    check(32'(core_clock_select_out), 32'h8);
    rd(OFS_STATUS, 32'h0000_0099);
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 32'h0000_0099);
    wr(OFS_STATUS, 32'h80);
    rd(OFS_STATUS, 32'h0000_0019);
    do_reset(1'b0);
    check(32'(core_clock_select_out), 32'h1);
    rd(OFS_CORE_TICK, 32'h0000_0038);
    rd(OFS_PERIPH_SRC, 32'hffff_ffff);
    idle(3);
    summarize();
  end
endmodule // cgsc_top_tb
